/* File: hw/cmc_defs.svh */
// constants for the console monitor command parser
`ifndef CMC_DEFS_SVH
`define CMC_DEFS_SVH
// characters, seven bit codes for parsing
`define CMC_CH_SLASH 7'h2f
`define CMC_CH_DOLLAR 7'h24
`define CMC_CH_R 7'h52
`define CMC_CH_S 7'h53
`define CMC_CH_G 7'h47
`define CMC_CH_P 7'h50
`define CMC_CH_H 7'h48
`define CMC_CH_DUMP 7'h13
`define CMC_CH_NUL7 7'h00
`define CMC_CH_STX7 7'h02
`define CMC_CH_BS7 7'h08
`define CMC_CH_CR7 7'h0d
`define CMC_CH_LF7 7'h0a
`define CMC_DIG_HI 4'h6
// characters generated internally, bit 7 clear
`define CMC_CH_CR 8'h0d
`define CMC_CH_LF 8'h0a
`define CMC_CH_AT 8'h40
`define CMC_CH_QM 8'h3f
`define CMC_CH_SP 8'h20
`define CMC_CH_NUL 8'h00
`define CMC_CH_0 8'h30
// addresses and fields
`define CMC_PSW_ADDR 22'h3ffffe
`define CMC_GPR_WIN 19'h7fff8
`define CMC_TRACE_BIT 4
`define CMC_PC_IDX 3'h7
`define CMC_WORD_STEP 16'h0002
`define CMC_DUMP_BYTES 4'h8
`define CMC_ENTRY_DIGITS 8
// timing
`define CMC_CLK_NS 8
`define CMC_INIT_NS 12600
`define CMC_WAIT_NS 110000
`define CMC_INIT_CYC ((`CMC_INIT_NS + `CMC_CLK_NS - 1) / `CMC_CLK_NS)
`define CMC_WAIT_CYC ((`CMC_WAIT_NS + `CMC_CLK_NS - 1) / `CMC_CLK_NS)
`define CMC_TIMER_W 16
`endif

/* File: hw/cmc_pkg.sv */
// types shared by the console monitor files
package cmc_pkg;
  typedef enum logic [1:0] {TGT_GPR = 2'h0, TGT_PSW = 2'h1, TGT_FPS = 2'h2} cmc_tgt_t;
  typedef struct packed {
    logic we;
    cmc_tgt_t tgt;
    logic [2:0] idx;
    logic [1:0] spMode;
    logic [15:0] wdata;
  } cmc_reg_cmd_t;
  typedef struct packed {
    logic we;
    logic [21:0] addr;
    logic [15:0] wdata;
  } cmc_bus_cmd_t;
  typedef enum logic [4:0] {
    P1_IDLE = 5'h00, P2_REGDES = 5'h01, P6_RENT = 5'h03, P5_AENT = 5'h02,
    P3_AOPEN = 5'h06, P7_ADATA = 5'h07, P4_ROPEN = 5'h05, P8_RDATA = 5'h04,
    P9_PREV = 5'h0c, P10_DUMP = 5'h0d, S_EMIT = 5'h0f, S_ACC = 5'h0e,
    S_CLOSE = 5'h0a, S_GOREG = 5'h0b, S_GOINIT = 5'h09, S_GOWAIT = 5'h08,
    S_RUN = 5'h18, S_PCRD = 5'h19, S_DUMPRD = 5'h1b
  } cmc_state_t;
endpackage

/* File: hw/cmc_octal_entry.sv */
// octal digit accumulator keeping the last few digits typed
`timescale 1ns/1ps
`default_nettype none
module cmc_octal_entry #(
  parameter int unsigned DIGITS = 8
) (
  // clock and control
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // digit stream
  input wire logic clr,
  input wire logic shift,
  input wire logic [2:0] dig,
  // accumulated value
  output logic [3*DIGITS-1:0] value_ff
);
  // older digits fall off the top, missing ones stay zero
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      value_ff <= '0;
    end else if (clkEn) begin
      if (clr) begin
        value_ff <= '0;
      end else if (shift) begin
        value_ff <= {value_ff[3*DIGITS-4:0], dig};
      end
    end
  end
endmodule
`default_nettype wire

/* File: hw/cmc_delay.sv */
// loadable down counter for the bus init timing
`timescale 1ns/1ps
`default_nettype none
module cmc_delay #(
  parameter int unsigned W = 16
) (
  // clock and control
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // load and status
  input wire logic load,
  input wire logic [W-1:0] loadVal,
  output logic zero
);
  logic [W-1:0] count_ff;
  // counts down to zero and rests there
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      count_ff <= '0;
    end else if (clkEn) begin
      if (load) begin
        count_ff <= loadVal;
      end else if (count_ff != '0) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
  assign zero = (count_ff == '0);
endmodule
`default_nettype wire

/* File: hw/cmc_console_monitor.sv */
// console monitor command parser, top level
`timescale 1ns/1ps
`default_nettype none
`include "cmc_defs.svh"
module cmc_console_monitor
  import cmc_pkg::*;
#(
  parameter int unsigned WAIT_CYC = `CMC_WAIT_CYC
) (
  // clock and control
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // serial receive and transmit
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic txReady,
  output logic txValid_ff,
  output logic [7:0] txData_ff,
  // system bus access
  output logic busReq_ff,
  output var cmc_bus_cmd_t busCmd_ff,
  input wire logic busAck,
  input wire logic busTimeout,
  input wire logic [15:0] busRData,
  // processor register access
  output logic regReq_ff,
  output var cmc_reg_cmd_t regCmd_ff,
  input wire logic regAck,
  input wire logic [15:0] regRData,
  // processor state and bus lines
  input wire logic [15:0] psw,
  input wire logic instrBoundary,
  input wire logic busHaltLine_b,
  output logic busInitLine_b_ff,
  output logic consoleActive_ff
);
  localparam int unsigned INIT_CYC = `CMC_INIT_CYC;
  localparam int unsigned DIGS = `CMC_ENTRY_DIGITS;

  cmc_state_t state_ff, ret_ff;
  logic [79:0] buf_ff;
  logic [3:0] bufLen_ff;
  logic [21:0] locAddr_ff;
  logic [2:0] locIdx_ff, desIdx_ff;
  logic locIsReg_ff, locPsw_ff, locValid_ff, desPsw_ff;
  logic opWe_ff, lfClose_ff, dumpHi_ff, tLoad_ff, entClr_ff;
  logic [15:0] dumpAddr_ff, tVal_ff, rdW;
  logic [3:0] dumpCnt_ff;
  logic [1:0] goStep_ff;
  logic haltS1_b_ff, haltS2_b_ff;
  logic [3*DIGS-1:0] entVal;
  logic [6:0] ch;
  logic isDig, quiet, entShift, tZero, accDone, busDone;
  cmc_state_t promptSt;

  // six octal characters of a word, first character in the low byte
  function automatic logic [47:0] oct6(input logic [15:0] w);
    return {`CMC_CH_0 | {5'h0, w[2:0]}, `CMC_CH_0 | {5'h0, w[5:3]},
            `CMC_CH_0 | {5'h0, w[8:6]}, `CMC_CH_0 | {5'h0, w[11:9]},
            `CMC_CH_0 | {5'h0, w[14:12]}, `CMC_CH_0 | {7'h0, w[15]}};
  endfunction

  // character classes, bit 7 dropped for parsing
  always_comb begin
    ch = rxData[6:0];
    isDig = (ch[6:3] == `CMC_DIG_HI);
    quiet = (ch == `CMC_CH_NUL7) || (ch == `CMC_CH_STX7) || (ch == `CMC_CH_BS7) ||
            (ch == `CMC_CH_LF7);
    entShift = rxValid && isDig && (state_ff inside {P1_IDLE, P5_AENT, P9_PREV, P3_AOPEN,
               P7_ADATA, P4_ROPEN, P8_RDATA});
    busDone = busReq_ff && (busAck || busTimeout);
    accDone = busDone || (regReq_ff && regAck);
    rdW = regReq_ff ? regRData : busRData;
    promptSt = locValid_ff ? P9_PREV : P1_IDLE;
  end

  cmc_octal_entry #(.DIGITS(DIGS)) u_entry (
    .core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn), .clr(entClr_ff),
    .shift(entShift), .dig(ch[2:0]), .value_ff(entVal));

  cmc_delay #(.W(`CMC_TIMER_W)) u_delay (
    .core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn), .load(tLoad_ff),
    .loadVal(tVal_ff), .zero(tZero));

  // halt line synchroniser
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      haltS1_b_ff <= 1'b1;
      haltS2_b_ff <= 1'b1;
    end else if (clkEn) begin
      haltS1_b_ff <= busHaltLine_b;
      haltS2_b_ff <= haltS1_b_ff;
    end
  end

  // parser, access sequencer and output engine
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_ff <= P1_IDLE;
      ret_ff <= P1_IDLE;
      buf_ff <= '0;
      bufLen_ff <= 4'h0;
      locAddr_ff <= '0;
      locIdx_ff <= 3'h0;
      desIdx_ff <= 3'h0;
      {locIsReg_ff, locPsw_ff, locValid_ff, desPsw_ff} <= 4'h0;
      {opWe_ff, lfClose_ff, dumpHi_ff, tLoad_ff, entClr_ff} <= 5'h0;
      dumpAddr_ff <= 16'h0000;
      dumpCnt_ff <= 4'h0;
      tVal_ff <= 16'h0000;
      goStep_ff <= 2'h0;
      txValid_ff <= 1'b0;
      txData_ff <= 8'h00;
      busReq_ff <= 1'b0;
      busCmd_ff <= '0;
      regReq_ff <= 1'b0;
      regCmd_ff <= '0;
      busInitLine_b_ff <= 1'b1;
      consoleActive_ff <= 1'b1;
    end else if (clkEn) begin
      entClr_ff <= 1'b0;
      tLoad_ff <= 1'b0;
      unique case (state_ff)
        P1_IDLE, P2_REGDES, P3_AOPEN, P4_ROPEN, P5_AENT, P6_RENT, P7_ADATA, P8_RDATA,
        P9_PREV: if (rxValid) begin
          state_ff <= S_EMIT;
          buf_ff <= {72'h0, rxData};
          bufLen_ff <= 4'h1;
          if (isDig && (state_ff inside {P2_REGDES, P6_RENT})) begin
            desIdx_ff <= ch[2:0];
            desPsw_ff <= 1'b0;
            ret_ff <= P6_RENT;
          end else if (isDig) begin
            ret_ff <= (state_ff inside {P3_AOPEN, P7_ADATA}) ? P7_ADATA :
                      (state_ff inside {P4_ROPEN, P8_RDATA}) ? P8_RDATA : P5_AENT;
          end else if ((ch == `CMC_CH_R || ch == `CMC_CH_DOLLAR) &&
                       (state_ff inside {P1_IDLE, P9_PREV})) begin
            ret_ff <= P2_REGDES;
          end else if (ch == `CMC_CH_S && (state_ff inside {P2_REGDES, P6_RENT})) begin
            desPsw_ff <= 1'b1;
            ret_ff <= P6_RENT;
          end else if (ch == `CMC_CH_SLASH &&
                       (state_ff inside {P5_AENT, P6_RENT, P9_PREV})) begin
            if (state_ff == P5_AENT) begin
              locAddr_ff <= {entVal[21:1], 1'b0};
              locIsReg_ff <= ({entVal[21:1], 1'b0} == `CMC_PSW_ADDR);
              locPsw_ff <= ({entVal[21:1], 1'b0} == `CMC_PSW_ADDR);
            end else if (state_ff == P6_RENT) begin
              locIsReg_ff <= 1'b1;
              locPsw_ff <= desPsw_ff;
              locIdx_ff <= desIdx_ff;
            end
            locValid_ff <= 1'b1;
            opWe_ff <= 1'b0;
            ret_ff <= S_ACC;
          end else if ((ch == `CMC_CH_CR7 || ch == `CMC_CH_LF7) &&
                       (state_ff inside {P3_AOPEN, P4_ROPEN, P7_ADATA, P8_RDATA})) begin
            lfClose_ff <= (ch == `CMC_CH_LF7);
            opWe_ff <= (state_ff inside {P7_ADATA, P8_RDATA});
            ret_ff <= (state_ff inside {P7_ADATA, P8_RDATA}) ? S_ACC : S_CLOSE;
            if (ch == `CMC_CH_LF7) begin
              bufLen_ff <= 4'h0;
            end
          end else if (ch == `CMC_CH_G && (state_ff inside {P1_IDLE, P5_AENT, P9_PREV})) begin
            buf_ff <= {56'h0, `CMC_CH_NUL, `CMC_CH_NUL, rxData};
            bufLen_ff <= 4'h3;
            goStep_ff <= 2'h0;
            ret_ff <= S_GOREG;
          end else if (ch == `CMC_CH_P && (state_ff inside {P1_IDLE, P9_PREV})) begin
            ret_ff <= S_RUN;
          end else if (ch == `CMC_CH_DUMP && (state_ff inside {P1_IDLE, P9_PREV})) begin
            dumpHi_ff <= 1'b1;
            ret_ff <= P10_DUMP;
          end else if (ch == `CMC_CH_H && (state_ff inside {P1_IDLE, P9_PREV})) begin
            buf_ff <= {48'h0, `CMC_CH_AT, `CMC_CH_LF, `CMC_CH_CR, rxData};
            bufLen_ff <= 4'h4;
            ret_ff <= promptSt;
          end else begin
            buf_ff <= quiet ? {48'h0, `CMC_CH_AT, `CMC_CH_LF, `CMC_CH_CR, `CMC_CH_QM} :
                      {40'h0, `CMC_CH_AT, `CMC_CH_LF, `CMC_CH_CR, `CMC_CH_QM, rxData};
            bufLen_ff <= quiet ? 4'h4 : 4'h5;
            ret_ff <= promptSt;
          end
        end
        P10_DUMP: if (rxValid) begin
          if (dumpHi_ff) begin
            dumpAddr_ff[15:8] <= rxData;
            dumpHi_ff <= 1'b0;
          end else begin
            dumpAddr_ff[7:0] <= rxData;
            dumpCnt_ff <= 4'h0;
            state_ff <= S_DUMPRD;
          end
        end
        S_EMIT: if (!txValid_ff || txReady) begin
          txValid_ff <= (bufLen_ff != 4'h0);
          txData_ff <= buf_ff[7:0];
          buf_ff <= {8'h00, buf_ff[79:8]};
          if (bufLen_ff != 4'h0) begin
            bufLen_ff <= bufLen_ff - 4'h1;
          end else begin
            state_ff <= ret_ff;
            entClr_ff <= (ret_ff inside {P1_IDLE, P3_AOPEN, P4_ROPEN, P9_PREV});
            if (ret_ff == S_RUN) begin
              consoleActive_ff <= 1'b0;
            end
          end
        end
        S_ACC: if (accDone) begin
          busReq_ff <= 1'b0;
          regReq_ff <= 1'b0;
          state_ff <= S_EMIT;
          if (busReq_ff && busTimeout) begin
            buf_ff <= {48'h0, `CMC_CH_AT, `CMC_CH_LF, `CMC_CH_CR, `CMC_CH_QM};
            bufLen_ff <= 4'h4;
            ret_ff <= promptSt;
          end else if (!opWe_ff) begin
            buf_ff <= {24'h0, `CMC_CH_SP, oct6(rdW)};
            bufLen_ff <= 4'h7;
            ret_ff <= locIsReg_ff ? P4_ROPEN : P3_AOPEN;
          end else begin
            state_ff <= S_CLOSE;
          end
        end else if (!busReq_ff && !regReq_ff) begin
          if (locIsReg_ff) begin
            regReq_ff <= 1'b1;
            regCmd_ff.we <= opWe_ff;
            regCmd_ff.tgt <= locPsw_ff ? TGT_PSW : TGT_GPR;
            regCmd_ff.idx <= locIdx_ff;
            regCmd_ff.spMode <= psw[15:14];
            regCmd_ff.wdata <= entVal[15:0];
            if (locPsw_ff) begin
              regCmd_ff.wdata[`CMC_TRACE_BIT] <= psw[`CMC_TRACE_BIT];
            end
          end else if (locAddr_ff[21:3] == `CMC_GPR_WIN) begin
            buf_ff <= {48'h0, `CMC_CH_AT, `CMC_CH_LF, `CMC_CH_CR, `CMC_CH_QM};
            bufLen_ff <= 4'h4;
            ret_ff <= promptSt;
            state_ff <= S_EMIT;
          end else begin
            busReq_ff <= 1'b1;
            busCmd_ff <= '{we: opWe_ff, addr: locAddr_ff, wdata: entVal[15:0]};
          end
        end
        S_CLOSE: begin
          state_ff <= S_EMIT;
          if (lfClose_ff && !locPsw_ff) begin
            locIdx_ff <= locIdx_ff + 3'h1;
            if (!locIsReg_ff) begin
              locAddr_ff[15:0] <= locAddr_ff[15:0] + `CMC_WORD_STEP;
            end
            opWe_ff <= 1'b0;
            buf_ff <= {64'h0, `CMC_CH_LF, `CMC_CH_CR};
            bufLen_ff <= 4'h2;
            ret_ff <= S_ACC;
          end else begin
            buf_ff <= {56'h0, `CMC_CH_AT, `CMC_CH_LF, `CMC_CH_CR};
            bufLen_ff <= 4'h3;
            ret_ff <= P9_PREV;
            entClr_ff <= 1'b1;
          end
        end
        S_GOREG: if (regReq_ff && regAck) begin
          regReq_ff <= 1'b0;
          goStep_ff <= goStep_ff + 2'h1;
          if (goStep_ff == 2'h2) begin
            busInitLine_b_ff <= 1'b0;
            tLoad_ff <= 1'b1;
            tVal_ff <= 16'(INIT_CYC);
            state_ff <= S_GOINIT;
          end
        end else if (!regReq_ff) begin
          regReq_ff <= 1'b1;
          regCmd_ff.we <= 1'b1;
          regCmd_ff.idx <= `CMC_PC_IDX;
          regCmd_ff.spMode <= psw[15:14];
          regCmd_ff.tgt <= (goStep_ff == 2'h0) ? TGT_GPR :
                           (goStep_ff == 2'h1) ? TGT_FPS : TGT_PSW;
          regCmd_ff.wdata <= (goStep_ff == 2'h0) ? entVal[15:0] : 16'h0000;
        end
        S_GOINIT: if (!tLoad_ff && tZero) begin
          busInitLine_b_ff <= 1'b1;
          tLoad_ff <= 1'b1;
          tVal_ff <= 16'(WAIT_CYC);
          state_ff <= S_GOWAIT;
        end
        S_GOWAIT: if (!tLoad_ff && tZero) begin
          state_ff <= haltS2_b_ff ? S_RUN : S_PCRD;
          consoleActive_ff <= !haltS2_b_ff;
        end
        S_RUN: if (instrBoundary && !haltS2_b_ff) begin
          consoleActive_ff <= 1'b1;
          state_ff <= S_PCRD;
        end
        S_PCRD: if (regReq_ff && regAck) begin
          regReq_ff <= 1'b0;
          buf_ff <= {8'h0, `CMC_CH_AT, `CMC_CH_LF, `CMC_CH_CR, oct6(regRData)};
          bufLen_ff <= 4'h9;
          ret_ff <= promptSt;
          state_ff <= S_EMIT;
        end else if (!regReq_ff) begin
          regReq_ff <= 1'b1;
          regCmd_ff <= '{we: 1'b0, tgt: TGT_GPR, idx: `CMC_PC_IDX, spMode: psw[15:14],
                         wdata: 16'h0000};
        end
        S_DUMPRD: if (dumpCnt_ff == `CMC_DUMP_BYTES) begin
          buf_ff <= {56'h0, `CMC_CH_AT, `CMC_CH_LF, `CMC_CH_CR};
          bufLen_ff <= 4'h3;
          ret_ff <= promptSt;
          state_ff <= S_EMIT;
        end else if (busDone) begin
          busReq_ff <= 1'b0;
          state_ff <= S_EMIT;
          if (busTimeout) begin
            buf_ff <= {48'h0, `CMC_CH_AT, `CMC_CH_LF, `CMC_CH_CR, `CMC_CH_QM};
            bufLen_ff <= 4'h4;
            ret_ff <= promptSt;
          end else begin
            buf_ff <= {72'h0, dumpAddr_ff[0] ? busRData[15:8] : busRData[7:0]};
            bufLen_ff <= 4'h1;
            dumpAddr_ff <= dumpAddr_ff + 16'h0001;
            dumpCnt_ff <= dumpCnt_ff + 4'h1;
            ret_ff <= S_DUMPRD;
          end
        end else if (!busReq_ff) begin
          busReq_ff <= 1'b1;
          busCmd_ff <= '{we: 1'b0, addr: {6'h00, dumpAddr_ff[15:1], 1'b0}, wdata: 16'h0000};
        end
        default: state_ff <= P1_IDLE;
      endcase
    end
  end

  // checks: helper history and counters
  localparam int INIT_HI = `CMC_INIT_CYC + 2;
  localparam int WAIT_HI = int'(WAIT_CYC) + 2;
  logic [15:0] txHist_ff, initHi_ff, waitLo_ff;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      txHist_ff <= 16'hffff;
      initHi_ff <= 16'h0000;
      waitLo_ff <= 16'h0000;
    end else if (clkEn) begin
      if (txValid_ff && txReady) begin
        txHist_ff <= {txHist_ff[7:0], txData_ff};
      end
      initHi_ff <= busInitLine_b_ff ? 16'h0000 : initHi_ff + 16'h0001;
      waitLo_ff <= (state_ff == S_GOWAIT) ? waitLo_ff + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b || !clkEn);

  trace_keep_a: assert property ($rose(regReq_ff) && regCmd_ff.we && state_ff != S_GOREG &&
    regCmd_ff.tgt == TGT_PSW |-> regCmd_ff.wdata[`CMC_TRACE_BIT] == $past(psw[`CMC_TRACE_BIT]))
    else $error("trace bit changed by console write");
  go_nulls_a: assert property ($fell(busInitLine_b_ff) |-> txHist_ff == 16'h0000)
    else $error("bus init without two nulls sent");
  init_width_a: assert property ($rose(busInitLine_b_ff) |-> initHi_ff == 16'(INIT_HI))
    else $error("bus init width wrong");
  init_wait_a: assert property ($past(state_ff) == S_GOWAIT && state_ff != S_GOWAIT
    |-> waitLo_ff == 16'(WAIT_HI) && busInitLine_b_ff)
    else $error("post init wait wrong");
  dump_high_a: assert property (busReq_ff && state_ff == S_DUMPRD
    |-> busCmd_ff.addr[21:16] == 6'h00)
    else $error("dump address above 64 KB");
  even_addr_a: assert property (busReq_ff |-> !busCmd_ff.addr[0])
    else $error("odd bus address issued");
  gpr_window_a: assert property (busReq_ff |-> busCmd_ff.addr[21:3] != `CMC_GPR_WIN)
    else $error("register window reached the bus");
  sp_mode_a: assert property ($rose(regReq_ff) |-> regCmd_ff.spMode == $past(psw[15:14]))
    else $error("stack pointer mode not from status word");
  timeout_reply_a: assert property (busReq_ff && busTimeout
    |-> ##[1:3] (txValid_ff && txData_ff == `CMC_CH_QM))
    else $error("no question mark after bus timeout");

  go_run_c: cover property (state_ff == S_GOWAIT ##1 state_ff == S_RUN);
  proceed_c: cover property ($fell(consoleActive_ff) && state_ff == S_RUN);
  dump_c: cover property (state_ff == S_DUMPRD && dumpCnt_ff == `CMC_DUMP_BYTES);
  timeout_c: cover property (busReq_ff && busTimeout);
endmodule
`default_nettype wire

/* File: tb/cmc_term_model.sv */
// serial terminal model that takes console output and may stall
`timescale 1ns/1ps
`default_nettype none
module cmc_term_model (
  // clock
  input wire logic core_clk,
  // stall control
  input wire logic slow,
  // transmit side of the console
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady
);
  logic [7:0] logQ[$];
  logic [1:0] cnt = 2'h0;
  // ready one cycle in four while stalling
  assign txReady = !slow || (cnt == 2'h3);
  // keep every accepted character in order
  always @(posedge core_clk) begin
    cnt <= cnt + 2'h1;
    if (txValid && txReady) logQ.push_back(txData);
  end
endmodule
`default_nettype wire

/* File: tb/tb_cmc_console_monitor.sv */
// testbench for the console monitor command parser
`timescale 1ns/1ps
`default_nettype none
module tb_cmc_console_monitor;
  import cmc_pkg::*;
  logic core_clk, rst_b, rxValid, txReady, txValid_ff, busReq_ff, busAck, busTimeout, bDone;
  logic regReq_ff, regAck, instrBoundary, busHaltLine_b, busInitLine_b_ff, consoleActive_ff;
  logic slow, rDone;
  logic [7:0] rxData, txData_ff;
  logic [15:0] busRData, regRData, psw, pcVal, a, w;
  cmc_bus_cmd_t busCmd_ff;
  cmc_reg_cmd_t regCmd_ff, lastReg;
  int n_mismatch = 0;
  int tests_run = 0;
  int n;
  string s;
  // clock source
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  cmc_console_monitor #(.WAIT_CYC(20)) i_dut (.core_clk(core_clk), .rst_b(rst_b), .clkEn(1'b1),
    .rxValid(rxValid), .rxData(rxData), .txReady(txReady), .txValid_ff(txValid_ff),
    .txData_ff(txData_ff), .busReq_ff(busReq_ff), .busCmd_ff(busCmd_ff), .busAck(busAck),
    .busTimeout(busTimeout), .busRData(busRData), .regReq_ff(regReq_ff), .regCmd_ff(regCmd_ff),
    .regAck(regAck), .regRData(regRData), .psw(psw), .instrBoundary(instrBoundary),
    .busHaltLine_b(busHaltLine_b), .busInitLine_b_ff(busInitLine_b_ff),
    .consoleActive_ff(consoleActive_ff));
  cmc_term_model i_term (.core_clk(core_clk), .slow(slow), .txValid(txValid_ff),
    .txData(txData_ff), .txReady(txReady));
  // memory answers below 64 KB, anything higher times out; registers answer once each
  always @(posedge core_clk) begin
    busAck <= 1'b0;
    busTimeout <= 1'b0;
    regAck <= 1'b0;
    if (!busReq_ff) bDone <= 1'b0;
    else if (!bDone) begin
      bDone <= 1'b1;
      busTimeout <= busCmd_ff.addr[21:16] != 6'h00;
      busAck <= busCmd_ff.addr[21:16] == 6'h00;
      busRData <= busCmd_ff.addr[15:0] ^ 16'h5a5a;
    end
    if (!regReq_ff) rDone <= 1'b0;
    else if (!rDone) begin
      rDone <= 1'b1;
      regAck <= 1'b1;
      lastReg <= regCmd_ff;
      if (regCmd_ff.we && regCmd_ff.tgt == TGT_GPR && regCmd_ff.idx == 3'h7) pcVal <= regCmd_ff.wdata;
    end
  end
  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // wait until output and accesses have been quiet for ten cycles
  task automatic idle();
    n = 0;
    for (int k = 0; k < 4000 && n < 10; k++) begin
      @(posedge core_clk);
      n = (txValid_ff || busReq_ff || regReq_ff) ? 0 : n + 1;
    end
  endtask
  task automatic typ(input string t);
    for (int i = 0; i < t.len(); i++) begin
      @(posedge core_clk);
      #1 rxValid = 1'b1;
      rxData = t[i];
      @(posedge core_clk);
      #1 rxValid = 1'b0;
      idle();
    end
  endtask
  // compare the end of the captured output, then clear it
  task automatic tail(input string name, input string t);
    int b;
    b = i_term.logQ.size() - t.len();
    for (int i = 0; i < t.len(); i++) cmp(i_term.logQ[b + i], {32'h0, t[i]});
    $display("test %s done", name);
    i_term.logQ.delete();
  endtask
  function automatic string oct6(input logic [15:0] v);
    return $sformatf("%o%05o ", v[15], v[14:0]);
  endfunction
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end
  initial begin
    rst_b = 0; rxValid = 0; rxData = 0; slow = 0; psw = 16'hc000; instrBoundary = 0;
    busHaltLine_b = 1; regRData = 16'h1234;
    repeat (4) @(posedge core_clk);
    #1 rst_b = 1;
    typ("H"); tail("reserved", "H\015\012@");
    typ("X\002"); tail("invalid", "X?\015\012@?\015\012@");
    typ("\310"); tail("parity", "\310\015\012@");
    typ("1001/"); tail("odd", {"1001/", oct6(16'h0200 ^ 16'h5a5a)});
    typ("\015/"); tail("reopen", {"\015\015\012@/", oct6(16'h0200 ^ 16'h5a5a)});
    typ("\012"); tail("step", {"\015\012", oct6(16'h0202 ^ 16'h5a5a)});
    typ("\01517777700/"); tail("regwin", "?\015\012@");
    typ("17600000/"); tail("nonexist", "?\015\012@");
    typ("R6/"); cmp({lastReg.idx, lastReg.spMode}, {3'h6, 2'h3});
    typ("\015RS/177777\015"); cmp({lastReg.we, lastReg.tgt, lastReg.wdata}, {1'b1, TGT_PSW, 16'hffef});
    $display("test regs done");
    typ("RS/\012"); tail("status lf", {"RS/", oct6(16'h1234), "\015\012@"});
    slow = 1;
    s = "\023";
    for (int k = 0; k < 8; k++) begin
      a = 16'h4040 + k;
      w = {a[15:1], 1'b0} ^ 16'h5a5a;
      s = {s, string'(a[0] ? w[15:8] : w[7:0])};
    end
    typ("\023@@"); tail("dump", {s, "\015\012@"});
    slow = 0;
    typ("P"); cmp(consoleActive_ff, 1'b0);
    #1 busHaltLine_b = 0;
    instrBoundary = 1;
    for (n = 0; n < 100 && !consoleActive_ff; n++) @(posedge core_clk);
    idle(); tail("halt", "P011064\015\012@");
    #1 instrBoundary = 0;
    busHaltLine_b = 1;
    typ("200"); tail("digits", "200");
    @(posedge core_clk);
    #1 rxValid = 1'b1;
    rxData = "G";
    @(posedge core_clk);
    #1 rxValid = 1'b0;
    for (n = 0; n < 200 && busInitLine_b_ff; n++) @(posedge core_clk);
    cmp(i_term.logQ.size(), 3);
    cmp({i_term.logQ[0], i_term.logQ[1], i_term.logQ[2]}, 24'h470000);
    cmp({pcVal, lastReg.tgt, lastReg.wdata}, {16'o200, TGT_PSW, 16'h0000});
    n = 0;
    while (!busInitLine_b_ff && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    cmp(n >= 1575 && n < 3000, 1'b1);
    repeat (40) @(posedge core_clk);
    cmp(consoleActive_ff, 1'b0);
    $display("test go done");
    conclude();
  end
endmodule
`default_nettype wire
